// ===== mrc_board_sup.sv
// mrc_board_sup.sv: board supervisor model driving the reset pins
// assumes: pins pulled up on the board, changed 1 ns after mclk rises
`timescale 1ns/1ps
`default_nettype none
module mrc_board_sup #(
    parameter int NCORE = 2
) (
    input wire logic mclk,
    output logic por_n,
    output logic full_chip_reset_n,
    output logic warm_reset_n,
    output logic [NCORE-1:0] core_local_reset_n
);
    localparam int WARM_MIN = 24;
    // supplies ramp at start, so power-on held low
    initial begin
        por_n = 1'h0;
        full_chip_reset_n = 1'h1;
        warm_reset_n = 1'h1;
        core_local_reset_n = '1;
    end
    // sel: 0 power-on, 1 full, 2 warm, 3 local core 0
    task automatic drive(input int sel, input logic v);
        @(posedge mclk);
        #1;
        case (sel)
            0: por_n = v;
            1: full_chip_reset_n = v;
            2: warm_reset_n = v;
            default: core_local_reset_n[0] = v;
        endcase
    endtask
    // warm pulses never shorter than the minimum; power-on untouched
    task automatic pulse(input int sel, input int n);
        drive(sel, 1'h0);
        repeat ((sel == 2 && n < WARM_MIN) ? WARM_MIN : n) @(posedge mclk);
        drive(sel, 1'h1);
    endtask
endmodule // mrc_board_sup
`default_nettype wire

// ===== mrc_ctrl.sv
// mrc_ctrl.sv: multicore reset controller, sequencing and distribution of reset
// assumes: one reference clock mclk; pins arrive asynchronous, requests from mclk logic
//
// Behaviour
// - low power-on or full-reset pin gives total reset, latches config, starts rom boot
// - hard reset resets all but plls, test, emulation and isolation logic
// - pin, software, watchdog, emulation request hard; config turns first three soft
// - status output low once reset, high only after initialization completes
// - hard and soft resets keep the earlier latched boot configuration
// - soft reset keeps memory-interface registers; only ddr and pcie machines reset
// - soft reset keeps peripheral clock/power enables, plls locked, clocks running
// - soft reset ends with about 8 cycle clock pause, boot after restart
// - power-on puts main clock controller in bypass; other resets leave it alone
// - pins high-impedance while power-on pin low, reset state on release
// - after power-on all power-managed peripherals disabled until software enables
// - power-on release latches sampled pins, plls start locking, init starts
// - after power-on init clocks pause 10 cycles, restart at default dividers
// - reset released only when power-on and warm pins both high
// - local reset hits only its core, no rom boot, status unchanged
// - watchdog timeout gives local, nmi, nmi then local, or hard reset
// - simultaneous requests: only the highest ranked acts, power-on first
// - during warm reset affected modules' pins are high-impedance
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defs.svh"

module mrc_ctrl #(
    parameter int NCORE = `MRC_NCORE_DEF,
    parameter int INIT_CYC = `MRC_INIT_CYC_DEF,
    parameter int NMI_DELAY = `MRC_NMI_DELAY_DEF,
    parameter int CFG_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic por_n,
    input wire logic full_chip_reset_n,
    input wire logic warm_reset_n,
    input wire logic [NCORE-1:0] core_local_reset_n,
    input wire logic [CFG_W-1:0] boot_cfg_pins,
    input wire logic sw_reset_req,
    input wire logic emu_reset_req,
    input wire logic [2:0] reset_type_config_reg,
    input wire logic wd_timeout,
    input wire logic [2:0] core_select_field,
    input wire logic [1:0] watchdog_reset_config_reg,
    input wire logic [NCORE-1:0] local_power_sleep_ctrl_core_reset,
    output logic reset_status_n,
    output logic [CFG_W-1:0] device_status_reg,
    output mrc_pkg::mrc_dom_t dom,
    output logic ddr_pcie_sm_rst,
    output logic periph_pwr_rst,
    output logic [NCORE-1:0] core_rst,
    output logic [NCORE-1:0] core_nmi,
    output mrc_pkg::mrc_rtype_t last_reset_type
);
    localparam int CW = 16;
    localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);
    localparam logic [CW-1:0] POR_PAUSE_LAST = CW'(`MRC_POR_PAUSE_CYC - 1);
    localparam logic [CW-1:0] SOFT_PAUSE_LAST = CW'(`MRC_SOFT_PAUSE_CYC - 1);
    localparam logic [CW-1:0] NMI_LAST = CW'(NMI_DELAY - 1);

    initial begin
        if (NCORE < 1 || NCORE > 8 || INIT_CYC < 1 || NMI_DELAY < 1 || INIT_CYC > 65535)
            $error("mrc_ctrl: parameter out of range");
    end

    // three-stage pin synchronisers; a change counts when stages two and three agree
    function automatic logic settled(input logic [`MRC_SYNC_W-1:0] s, input logic old);
        settled = (s[1] == s[2]) ? s[2] : old;
    endfunction

    logic [`MRC_SYNC_W-1:0] por_s_r, full_s_r, warm_s_r;
    logic por_q_r, full_q_r, warm_q_r;

    // pins idle high, so synchronisers reset high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            por_s_r <= '1;
            full_s_r <= '1;
            warm_s_r <= '1;
        end else begin
            por_s_r <= {por_s_r[1:0], por_n};
            full_s_r <= {full_s_r[1:0], full_chip_reset_n};
            warm_s_r <= {warm_s_r[1:0], warm_reset_n};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            por_q_r <= 1'b0;
            full_q_r <= 1'b1;
            warm_q_r <= 1'b1;
        end else begin
            por_q_r <= settled(por_s_r, por_q_r);
            full_q_r <= settled(full_s_r, full_q_r);
            warm_q_r <= settled(warm_s_r, warm_q_r);
        end
    end

    // local reset pins, one synchroniser per core
    logic [NCORE-1:0] loc_q_r;
    genvar g;
    generate
        for (g = 0; g < NCORE; g++) begin : g_loc
            logic [`MRC_SYNC_W-1:0] s_r;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    s_r <= '1;
                    loc_q_r[g] <= 1'b1;
                end else begin
                    s_r <= {s_r[1:0], core_local_reset_n[g]};
                    loc_q_r[g] <= settled(s_r, loc_q_r[g]);
                end
            end
        end
    endgenerate

    // internal requests are same-clock; edge-detect so each is taken once
    logic sw_d_r, emu_d_r, wd_d_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sw_d_r <= 1'b0;
            emu_d_r <= 1'b0;
            wd_d_r <= 1'b0;
        end else begin
            sw_d_r <= sw_reset_req;
            emu_d_r <= emu_reset_req;
            wd_d_r <= wd_timeout;
        end
    end
    logic sw_ev, emu_ev, wd_ev;
    assign sw_ev = sw_reset_req & ~sw_d_r;
    assign emu_ev = emu_reset_req & ~emu_d_r;
    assign wd_ev = wd_timeout & ~wd_d_r;

    logic wd_hard;
    assign wd_hard = wd_ev && (watchdog_reset_config_reg == `MRC_WD_ACT_HARD);

    // request classification and priority
    logic por_req, warm_low;
    logic hard_req, soft_req;
    assign por_req = ~por_q_r | ~full_q_r;
    // warm pin taken as a level, so a low that outlasts a pause still resets
    assign warm_low = ~warm_q_r;
    // emulation is always hard; other three follow their config bit
    assign hard_req = emu_ev
        | (warm_low & ~reset_type_config_reg[`MRC_CFG_PIN])
        | (sw_ev & ~reset_type_config_reg[`MRC_CFG_SW])
        | (wd_hard & ~reset_type_config_reg[`MRC_CFG_WD]);
    assign soft_req = (warm_low & reset_type_config_reg[`MRC_CFG_PIN])
        | (sw_ev & reset_type_config_reg[`MRC_CFG_SW])
        | (wd_hard & reset_type_config_reg[`MRC_CFG_WD]);

    mrc_pkg::mrc_state_t st_r;
    mrc_pkg::mrc_rtype_t typ_r;
    logic [CW-1:0] cnt_r;
    logic init_done, pause_done;
    assign init_done = (cnt_r == INIT_LAST);
    assign pause_done = (typ_r == mrc_pkg::MRC_RT_SOFT) ? (cnt_r == SOFT_PAUSE_LAST)
                                                       : (cnt_r == POR_PAUSE_LAST);

    // main sequencer; power-on beats hard beats soft
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= mrc_pkg::MRC_ST_POR;
            typ_r <= mrc_pkg::MRC_RT_POR;
            cnt_r <= '0;
        end else if (por_req) begin
            st_r <= mrc_pkg::MRC_ST_POR;
            typ_r <= mrc_pkg::MRC_RT_POR;
            cnt_r <= '0;
        end else begin
            case (st_r)
                mrc_pkg::MRC_ST_POR: begin
                    // leave only once the warm pin is also high
                    if (warm_q_r) st_r <= mrc_pkg::MRC_ST_INIT;
                    cnt_r <= '0;
                end
                mrc_pkg::MRC_ST_WARM: begin
                    if (warm_q_r) st_r <= mrc_pkg::MRC_ST_INIT;
                    cnt_r <= '0;
                end
                mrc_pkg::MRC_ST_INIT: begin
                    if (!warm_q_r) begin
                        st_r <= mrc_pkg::MRC_ST_WARM;
                        cnt_r <= '0;
                    end else if (init_done) begin
                        // hard reset leaves clocking alone, so no pause
                        st_r <= (typ_r == mrc_pkg::MRC_RT_HARD) ? mrc_pkg::MRC_ST_RUN
                                                                 : mrc_pkg::MRC_ST_PAUSE;
                        cnt_r <= '0;
                    end else cnt_r <= cnt_r + CW'(1);
                end
                mrc_pkg::MRC_ST_PAUSE: begin
                    if (pause_done) st_r <= mrc_pkg::MRC_ST_RUN;
                    cnt_r <= pause_done ? '0 : cnt_r + CW'(1);
                end
                mrc_pkg::MRC_ST_RUN: begin
                    cnt_r <= '0;
                    if (hard_req) begin
                        st_r <= mrc_pkg::MRC_ST_WARM;
                        typ_r <= mrc_pkg::MRC_RT_HARD;
                    end else if (soft_req) begin
                        st_r <= mrc_pkg::MRC_ST_WARM;
                        typ_r <= mrc_pkg::MRC_RT_SOFT;
                    end
                end
                default: begin
                    st_r <= mrc_pkg::MRC_ST_POR;
                    typ_r <= mrc_pkg::MRC_RT_POR;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // boot configuration caught on every release of power-on or full reset, with the warm pin high
    logic cfg_take;
    assign cfg_take = (st_r == mrc_pkg::MRC_ST_POR) && !por_req && warm_q_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) device_status_reg <= '0;
        else if (cfg_take) device_status_reg <= boot_cfg_pins;
    end

    // domain outputs, registered
    logic in_rst, is_por, is_soft;
    assign in_rst = (st_r == mrc_pkg::MRC_ST_POR) || (st_r == mrc_pkg::MRC_ST_WARM)
                    || (st_r == mrc_pkg::MRC_ST_INIT);
    assign is_por = (typ_r == mrc_pkg::MRC_RT_POR);
    assign is_soft = (typ_r == mrc_pkg::MRC_RT_SOFT);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dom <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
            reset_status_n <= 1'b0;
            ddr_pcie_sm_rst <= 1'b1;
            periph_pwr_rst <= 1'b1;
            last_reset_type <= mrc_pkg::MRC_RT_POR;
        end else begin
            dom.por_dom_rst <= (st_r == mrc_pkg::MRC_ST_POR);
            dom.hard_dom_rst <= in_rst && !is_soft;
            dom.soft_dom_rst <= in_rst;
            // pins float while power-on is held and during warm reset
            dom.pins_hiz <= (st_r == mrc_pkg::MRC_ST_POR) || (st_r == mrc_pkg::MRC_ST_WARM);
            dom.cfg_latch <= cfg_take;
            // boot as the paused clocks restart, or straight after hard init
            dom.rom_boot <= (st_r == mrc_pkg::MRC_ST_RUN && dom.clk_pause)
                            || (st_r == mrc_pkg::MRC_ST_INIT && init_done
                                && typ_r == mrc_pkg::MRC_RT_HARD && warm_q_r);
            // bypass only from power-on until first pause ends
            dom.pll_bypass <= is_por && (st_r != mrc_pkg::MRC_ST_RUN);
            // held for every cycle of the pause state, full count
            dom.clk_pause <= (st_r == mrc_pkg::MRC_ST_PAUSE);
            // status low while reset, high at end of initialization
            reset_status_n <= !in_rst;
            ddr_pcie_sm_rst <= in_rst;
            // peripheral enables cleared by power-on and hard, kept by soft
            periph_pwr_rst <= in_rst && !is_soft;
            if (in_rst) last_reset_type <= typ_r;
        end
    end

    // per-core local reset and watchdog nmi paths; status untouched
    logic nmi_wait_r;
    logic [CW-1:0] nmi_cnt_r;
    logic [2:0] nmi_core_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nmi_wait_r <= 1'b0;
            nmi_cnt_r <= '0;
            nmi_core_r <= '0;
        end else if (wd_ev && watchdog_reset_config_reg == `MRC_WD_ACT_NMI_LOCAL) begin
            nmi_wait_r <= 1'b1;
            nmi_cnt_r <= '0;
            nmi_core_r <= core_select_field;
        end else if (nmi_wait_r) begin
            nmi_wait_r <= (nmi_cnt_r != NMI_LAST);
            nmi_cnt_r <= nmi_cnt_r + CW'(1);
        end
    end

    generate
        for (g = 0; g < NCORE; g++) begin : g_core
            logic sel, nmi_fire, loc_fire;
            assign sel = (core_select_field == 3'(g));
            assign nmi_fire = wd_ev && sel && (watchdog_reset_config_reg == `MRC_WD_ACT_NMI
                || watchdog_reset_config_reg == `MRC_WD_ACT_NMI_LOCAL);
            assign loc_fire = (wd_ev && sel && watchdog_reset_config_reg == `MRC_WD_ACT_LOCAL)
                || (nmi_wait_r && nmi_cnt_r == NMI_LAST && nmi_core_r == 3'(g));
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    core_rst[g] <= 1'b1;
                    core_nmi[g] <= 1'b0;
                end else begin
                    // level sources plus one-cycle watchdog pulse
                    core_rst[g] <= in_rst || !loc_q_r[g] || local_power_sleep_ctrl_core_reset[g] || loc_fire;
                    core_nmi[g] <= nmi_fire;
                end
            end
        end
    endgenerate
endmodule // mrc_ctrl
`default_nettype wire

// ===== mrc_ctrl_asserts.sv
// mrc_ctrl_asserts.sv: port checks for the reset controller
// assumes: bound to mrc_ctrl, one clock mclk, rst async high
`timescale 1ns/1ps
`default_nettype none
module mrc_ctrl_asserts #(
    parameter int NCORE = 2,
    parameter int CFG_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic por_n,
    input wire logic full_chip_reset_n,
    input wire logic warm_reset_n,
    input wire logic reset_status_n,
    input wire logic [CFG_W-1:0] device_status_reg,
    input wire mrc_pkg::mrc_dom_t dom,
    input wire logic ddr_pcie_sm_rst,
    input wire logic periph_pwr_rst,
    input wire logic [NCORE-1:0] core_rst,
    input wire logic [NCORE-1:0] core_nmi,
    input wire mrc_pkg::mrc_rtype_t last_reset_type
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0] pause_len_r;
    // length of the running clock pause; short, so no saturation
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pause_len_r <= 4'h0;
        end else if (dom.clk_pause) begin
            pause_len_r <= pause_len_r + 4'h1;
        end else begin
            pause_len_r <= 4'h0;
        end
    end
    // 8 cycles covers pin sync plus the registered outputs
    sequence por_held_s;
        (!por_n || !full_chip_reset_n) [*8];
    endsequence
    sequence warm_held_s;
        (por_n && full_chip_reset_n && !warm_reset_n) [*8];
    endsequence
    sequence soft_only_s;
        dom.soft_dom_rst && !dom.hard_dom_rst;
    endsequence
    a_por_total_reset: assert property (por_held_s |-> !reset_status_n && dom.por_dom_rst)
        else $error("power-on pin did not reset the chip");
    a_por_pins_hiz: assert property (!por_n [*8] |-> dom.pins_hiz && dom.pll_bypass)
        else $error("pins or pll not parked under power-on");
    a_warm_enters_reset: assert property (
        warm_held_s |-> !reset_status_n && dom.pins_hiz)
        else $error("warm pin did not enter reset");
    a_release_needs_pins: assert property (
        $rose(reset_status_n) |-> $past(por_n, 4) && $past(warm_reset_n, 4))
        else $error("status released with a reset pin low");
    a_soft_keeps_power: assert property (
        soft_only_s |-> !periph_pwr_rst && !dom.pll_bypass)
        else $error("soft reset touched power or pll");
    a_soft_ddr_reset: assert property (soft_only_s |-> ddr_pcie_sm_rst)
        else $error("soft reset left ddr/pcie machines running");
    a_cfg_kept: assert property (
        dom.hard_dom_rst && last_reset_type != mrc_pkg::MRC_RT_POR |-> $stable(device_status_reg))
        else $error("straps relatched in warm reset");
    a_cfg_latch_seen: assert property ($changed(device_status_reg) |-> dom.cfg_latch)
        else $error("straps taken without the latch strobe");
    // pause spans 10 reference cycles after power-on, 8 after soft reset
    a_pause_len: assert property (
        $fell(dom.clk_pause) && pause_len_r != 4'h0
        |-> pause_len_r == ((last_reset_type == mrc_pkg::MRC_RT_POR) ? 4'hA : 4'h8))
        else $error("clock pause of wrong length");
    a_nmi_pulse: assert property (|core_nmi |=> ~|core_nmi)
        else $error("nmi longer than one cycle");
    a_local_quiet: assert property (
        $rose(|core_rst) && reset_status_n |=> reset_status_n && !dom.rom_boot)
        else $error("local reset disturbed status or boot");
endmodule // mrc_ctrl_asserts
bind mrc_ctrl mrc_ctrl_asserts #(.NCORE(NCORE), .CFG_W(CFG_W)) u_mrc_ctrl_asserts (
    .mclk, .rst, .por_n, .full_chip_reset_n, .warm_reset_n, .reset_status_n,
    .device_status_reg, .dom, .ddr_pcie_sm_rst, .periph_pwr_rst, .core_rst, .core_nmi,
    .last_reset_type);
`default_nettype wire

// ===== mrc_ctrl_tb.sv
// mrc_ctrl_tb.sv: self-checking bench for the reset controller
// assumes: package, design, board model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module mrc_ctrl_tb;
    localparam int NCORE = 2;
    localparam int CFG_W = 16;
    logic mclk, rst, por_n, full_chip_reset_n, warm_reset_n, soft_x;
    logic sw_reset_req, emu_reset_req, wd_timeout, reset_status_n;
    logic ddr_pcie_sm_rst, periph_pwr_rst;
    logic [NCORE-1:0] core_local_reset_n, local_power_sleep_ctrl_core_reset, core_rst, core_nmi, core_rst_q;
    logic [CFG_W-1:0] boot_cfg_pins, device_status_reg;
    logic [2:0] reset_type_config_reg, core_select_field;
    logic [1:0] watchdog_reset_config_reg;
    mrc_pkg::mrc_dom_t dom;
    mrc_pkg::mrc_rtype_t last_reset_type;
    int miscompares, num_checks;
    int rise_cnt[NCORE];
    int nmi_cnt[NCORE];
    int kind[7] = '{3, 3, 0, 0, 1, 2, 2};
    logic [2:0] cfg_tab[7] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h7, 3'h4, 3'h0};
    mrc_ctrl #(.NCORE(NCORE), .INIT_CYC(8), .NMI_DELAY(4), .CFG_W(CFG_W)) u_mrc_ctrl (.mclk,
        .rst, .por_n, .full_chip_reset_n, .warm_reset_n, .core_local_reset_n, .boot_cfg_pins,
        .sw_reset_req, .emu_reset_req, .reset_type_config_reg, .wd_timeout,
        .core_select_field, .watchdog_reset_config_reg, .local_power_sleep_ctrl_core_reset, .reset_status_n,
        .device_status_reg, .dom, .ddr_pcie_sm_rst, .periph_pwr_rst, .core_rst, .core_nmi,
        .last_reset_type);
    mrc_board_sup #(.NCORE(NCORE)) u_mrc_board_sup (.mclk, .por_n, .full_chip_reset_n,
        .warm_reset_n, .core_local_reset_n);
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    // pulse counters, since watchdog core pulses last one cycle only
    always @(posedge mclk) begin
        for (int i = 0; i < NCORE; i++) begin
            if (core_rst[i] === 1'h1 && core_rst_q[i] !== 1'h1) rise_cnt[i]++;
            if (core_nmi[i] === 1'h1) nmi_cnt[i]++;
        end
        core_rst_q <= core_rst;
    end
    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s", $time, what);
        end
    endtask
    task automatic chk_val(input logic [CFG_W-1:0] got, input logic [CFG_W-1:0] exp,
        input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s got %h", $time, what, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // bounded wait for the status output to reach a level
    task automatic wait_status(input logic lvl, input int lim);
        for (int i = 0; i < lim && reset_status_n !== lvl; i++) @(posedge mclk);
        // after release let any clock pause run out; requests during it are refused
        if (lvl) repeat (12) @(posedge mclk);
        #1;
        chk_bit(reset_status_n, lvl, "status level");
    endtask
    // k: 0 software, 1 emulation, 2 watchdog; one-cycle request
    task automatic req(input int k);
        @(posedge mclk);
        #1;
        sw_reset_req = (k == 0);
        emu_reset_req = (k == 1);
        wd_timeout = (k == 2);
        @(posedge mclk);
        #1;
        {sw_reset_req, emu_reset_req, wd_timeout} = 3'h0;
    endtask
    task automatic clr_cnt();
        rise_cnt = '{0, 0};
        nmi_cnt = '{0, 0};
    endtask
    // hang guard: the sequence needs only a few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        $display("BAD t=%0t timeout", $time);
        give_verdict();
    end
    initial begin
        rst = 1'h1;
        {sw_reset_req, emu_reset_req, wd_timeout} = 3'h0;
        reset_type_config_reg = 3'h0;
        core_select_field = 3'h1;
        watchdog_reset_config_reg = 2'h0;
        local_power_sleep_ctrl_core_reset = '0;
        boot_cfg_pins = 16'hA5C3;
        miscompares = 0;
        num_checks = 0;
        clr_cnt();
        repeat (6) @(posedge mclk);
        #1 rst = 1'h0;
        repeat (12) @(posedge mclk);
        #1;
        chk_bit(dom.pins_hiz, 1'h1, "pins driven under power-on");
        chk_bit(dom.pll_bypass, 1'h1, "pll not bypassed");
        chk_bit(reset_status_n, 1'h0, "status high under power-on");
        // warm pin outlasting power-on keeps the device in reset
        u_mrc_board_sup.drive(2, 1'h0);
        u_mrc_board_sup.drive(0, 1'h1);
        repeat (40) @(posedge mclk);
        #1;
        chk_bit(reset_status_n, 1'h0, "released with warm low");
        u_mrc_board_sup.drive(2, 1'h1);
        wait_status(1'h1, 300);
        chk_val(device_status_reg, 16'hA5C3, "straps");
        chk_val(CFG_W'(last_reset_type), CFG_W'(mrc_pkg::MRC_RT_POR), "kind");
        // every warm source, hard and soft; new straps must not be taken
        // ddr taken to be in self-refresh before each soft request
        boot_cfg_pins = 16'h0F0F;
        watchdog_reset_config_reg = 2'h3;
        for (int j = 0; j < 7; j++) begin
            reset_type_config_reg = cfg_tab[j];
            // config bit: 0 pin, 1 software, 2 watchdog; emulation never soft
            soft_x = (kind[j] == 3) ? cfg_tab[j][0] : (kind[j] == 0) ? cfg_tab[j][1]
                : (kind[j] == 2) ? cfg_tab[j][2] : 1'h0;
            if (kind[j] == 3) u_mrc_board_sup.pulse(2, 20);
            else req(kind[j]);
            wait_status(1'h0, 40);
            @(posedge mclk);
            #1;
            chk_bit(periph_pwr_rst, !soft_x, "peripheral power reset");
            chk_bit(dom.hard_dom_rst, !soft_x, "hard domain");
            chk_bit(ddr_pcie_sm_rst, 1'h1, "ddr/pcie machines");
            chk_bit(dom.pll_bypass, 1'h0, "pll disturbed");
            wait_status(1'h1, 300);
            chk_val(device_status_reg, 16'hA5C3, "straps relatched");
            chk_val(CFG_W'(last_reset_type), soft_x ? CFG_W'(mrc_pkg::MRC_RT_SOFT)
                : CFG_W'(mrc_pkg::MRC_RT_HARD), "kind");
        end
        // watchdog local, nmi, nmi then local on core 1
        for (int a = 0; a < 3; a++) begin
            watchdog_reset_config_reg = a[1:0];
            clr_cnt();
            req(2);
            repeat (20) @(posedge mclk);
            #1;
            chk_val(CFG_W'(rise_cnt[1]), (a != 1) ? 16'h1 : 16'h0, "core 1 reset");
            chk_val(CFG_W'(nmi_cnt[1]), (a != 0) ? 16'h1 : 16'h0, "core 1 nmi");
            chk_val(CFG_W'(rise_cnt[0]), 16'h0, "core 0 hit");
            chk_bit(reset_status_n, 1'h1, "status moved");
        end
        // local pin and power/sleep bit
        clr_cnt();
        u_mrc_board_sup.pulse(3, 5);
        local_power_sleep_ctrl_core_reset[1] = 1'h1;
        repeat (8) @(posedge mclk);
        #1;
        chk_bit(core_rst[1], 1'h1, "sleep bit ignored");
        local_power_sleep_ctrl_core_reset[1] = 1'h0;
        chk_val(CFG_W'(rise_cnt[0]), 16'h1, "local pin ignored");
        chk_bit(reset_status_n, 1'h1, "status moved");
        // software request overtaken by power-on, then full reset relatches
        req(0);
        u_mrc_board_sup.pulse(0, 10);
        wait_status(1'h1, 300);
        chk_val(CFG_W'(last_reset_type), CFG_W'(mrc_pkg::MRC_RT_POR), "priority");
        chk_val(device_status_reg, 16'h0F0F, "straps not latched");
        boot_cfg_pins = 16'h3C3C;
        u_mrc_board_sup.pulse(1, 10);
        wait_status(1'h1, 300);
        chk_val(device_status_reg, 16'h3C3C, "full reset straps");
        give_verdict();
    end
endmodule // mrc_ctrl_tb
`default_nettype wire

// ===== mrc_defs.svh
// mrc_defs.svh: timing counts and code points for the multicore reset controller
// assumes: included by mrc_pkg.sv and mrc_ctrl.sv, single reference clock at 200 MHz
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH

`define MRC_CLK_MHZ 200
`define MRC_WARM_MIN_CYC 24
`define MRC_POR_PAUSE_CYC 10
`define MRC_SOFT_PAUSE_CYC 8
`define MRC_INIT_CYC_DEF 64
`define MRC_NMI_DELAY_DEF 16
`define MRC_NCORE_DEF 2
`define MRC_WD_ACT_LOCAL 2'h0
`define MRC_WD_ACT_NMI 2'h1
`define MRC_WD_ACT_NMI_LOCAL 2'h2
`define MRC_WD_ACT_HARD 2'h3
`define MRC_CFG_PIN 0
`define MRC_CFG_SW 1
`define MRC_CFG_WD 2
`define MRC_SYNC_W 3

`endif

// ===== mrc_pkg.sv
// mrc_pkg.sv: types of the multicore reset controller
// assumes: mrc_defs.svh sits beside it
`include "mrc_defs.svh"

package mrc_pkg;
    // gray coded along por -> init -> pause -> run
    typedef enum logic [2:0] {
        MRC_ST_POR = 3'h0,
        MRC_ST_INIT = 3'h1,
        MRC_ST_PAUSE = 3'h3,
        MRC_ST_RUN = 3'h2,
        MRC_ST_WARM = 3'h6
    } mrc_state_t;

    typedef enum logic [1:0] {
        MRC_RT_NONE = 2'h0,
        MRC_RT_POR = 2'h1,
        MRC_RT_HARD = 2'h2,
        MRC_RT_SOFT = 2'h3
    } mrc_rtype_t;

    // reset domain outputs that travel together
    typedef struct packed {
        logic por_dom_rst;
        logic hard_dom_rst;
        logic soft_dom_rst;
        logic pins_hiz;
        logic cfg_latch;
        logic rom_boot;
        logic pll_bypass;
        logic clk_pause;
    } mrc_dom_t;
endpackage
